// >>> verilog/ccs_consts.svh
// constants for the clock source select and activity detect block
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH

// source numbering on the select field
`define CCS_NSRC 12
`define CCS_SEL_W 4
`define CCS_SRC_RING 4'h0
`define CCS_SRC_XTAL 4'h1
`define CCS_SRC_PLL0 4'h2
`define CCS_SRC_PLL240 4'h4
`define CCS_SRC_FDIV0 4'h5
`define CCS_SRC_LAST 4'hb
`define CCS_NPLL_PH 3
`define CCS_NFDIV 7

// generator numbering: pll, seven dividers, nine base outputs
`define CCS_NGEN 17
`define CCS_GEN_PLL 0
`define CCS_GEN_BASE0 8
`define CCS_GEN_SAFE 8
`define CCS_GEN_PCR 10

// register index map on the plain port
`define CCS_ADDR_W 5
`define CCS_REG_STATUS 5'h11
`define CCS_REG_RISE 5'h12
`define CCS_REG_FALL 5'h13
`define CCS_REG_BUSY 5'h14

// control word layout
`define CCS_CTRL_SEL_LSB 0
`define CCS_CTRL_SEL_MSB 3
`define CCS_CTRL_PD_BIT 8
`define CCS_STATUS_VALID_BIT 16

// timing in control-clock cycles
`define CCS_DET_LIMIT 6'h20
`define CCS_SW_TIMEOUT 6'h20
`define CCS_SW_HOLD 6'h02
`define CCS_CNT_W 6

`endif

// >>> verilog/ccs_pkg.sv
// types for the clock source select and activity detect block
package ccs_pkg;

    // gray sequence along the switch path
    typedef enum logic [1:0] {
        CCS_RUN = 2'b00,
        CCS_DRAIN = 2'b01,
        CCS_HOLD = 2'b11,
        CCS_RESUME = 2'b10
    } ccs_sw_state_t;

endpackage

// >>> verilog/ccs_clock_select.sv
// source selection fabric with activity detection and glitch-free switching
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "ccs_consts.svh"

// Function
// - illegal source choices are refused
// - illegal write keeps select, updates other fields
// - every generator resets onto ring oscillator
// - inactive sources are masked from selection
// - no edge within 32 cycles means inactive
// - all absent after reset, valid after 32
// - activation and deactivation raise events
// - base outputs take any source; safe/control ring only
// - dividers take pll phases, ring or crystal
// - pll input selectable from crystal
// - pll supplies three phases 0, 120, 240
// - sources may be shared by many generators
// - pll switches hold clock low until lock
// - other switches fast, glitch-free, short low
// - stuck-high old clock forced low after 32 on a switch
// - selected source dying still passes, still signals
// - ring oscillator never powers down
// - control logic runs on always-on slow clock
// - one pll and seven dividers as sources

module ccs_clock_select (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [`CCS_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic ring_osc_source,
    input wire logic xtal_clk,
    input wire logic [`CCS_NPLL_PH-1:0] pll_phase,
    input wire logic [`CCS_NFDIV-1:0] frac_dividers,
    input wire logic pll_lock,
    output logic [`CCS_NGEN-1:0] gen_clk,
    output logic [`CCS_NSRC-1:0] source_activity_status,
    output logic status_valid,
    output logic [`CCS_NSRC-1:0] src_up_evt,
    output logic [`CCS_NSRC-1:0] src_down_evt,
    output logic [`CCS_NGEN-1:0] switch_busy
);

    // ------------------------------------------------------------
    // source legality
    // ------------------------------------------------------------
    function automatic logic ccs_legal(
        input int gen,
        input logic [`CCS_SEL_W-1:0] src,
        input logic [`CCS_NSRC-1:0] act
    );
        logic ok;
        ok = 1'b0;
        // pll input takes the crystal only, dividers a primary or a pll phase
        if (gen == `CCS_GEN_PLL) begin
            ok = (src == `CCS_SRC_XTAL);
        end else if (gen < `CCS_GEN_BASE0) begin
            ok = (src <= `CCS_SRC_PLL240);
        end else if (gen == `CCS_GEN_SAFE || gen == `CCS_GEN_PCR) begin
            ok = (src == `CCS_SRC_RING);
        end else begin
            ok = (src <= `CCS_SRC_LAST);
        end
        // an absent source reads as illegal until it shows edges again
        ccs_legal = ok && (src <= `CCS_SRC_LAST) && act[src];
    endfunction

    // ------------------------------------------------------------
    // source input synchronisers
    // ------------------------------------------------------------
    // the whole block runs on the always-on control clock
    logic [`CCS_NSRC-1:0] src_raw;
    logic [`CCS_NSRC-1:0] src_m1;
    logic [`CCS_NSRC-1:0] src_s;
    logic [`CCS_NSRC-1:0] src_d;
    logic lock_m1;
    logic lock_s;

    // ring oscillator has no power-down input at all
    assign src_raw = {frac_dividers, pll_phase, xtal_clk, ring_osc_source};

    // src_d is a third stage that only feeds the edge detectors
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            src_m1 <= '0;
            src_s <= '0;
            src_d <= '0;
            lock_m1 <= 1'b0;
            lock_s <= 1'b0;
        end else begin
            src_m1 <= src_raw;
            src_s <= src_m1;
            src_d <= src_s;
            lock_m1 <= pll_lock;
            lock_s <= lock_m1;
        end
    end

    // ------------------------------------------------------------
    // activity detectors
    // ------------------------------------------------------------
    logic [`CCS_NSRC-1:0] active;
    logic [`CCS_NSRC-1:0] active_d;

    // sampling limits detection to sources well below half the control clock
    // each counter restarts on a rising edge and saturates at the limit
    genvar gs;
    generate
        for (gs = 0; gs < `CCS_NSRC; gs = gs + 1) begin : g_det
            logic [`CCS_CNT_W-1:0] idle_cnt;
            logic edge_seen;
            assign edge_seen = src_s[gs] & ~src_d[gs];

            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    idle_cnt <= '0;
                    active[gs] <= 1'b0;
                end else if (edge_seen) begin
                    idle_cnt <= '0;
                    active[gs] <= 1'b1;
                end else if (idle_cnt != `CCS_DET_LIMIT) begin
                    idle_cnt <= idle_cnt + `CCS_CNT_W'(1);
                    if (idle_cnt == `CCS_DET_LIMIT - `CCS_CNT_W'(1)) begin
                        active[gs] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            active_d <= '0;
            src_up_evt <= '0;
            src_down_evt <= '0;
        end else begin
            active_d <= active;
            // events fire even for a source in use, which keeps passing
            src_up_evt <= active & ~active_d;
            src_down_evt <= ~active & active_d;
        end
    end

    assign source_activity_status = active;

    // status only trustworthy once a full detect window has passed
    logic [`CCS_CNT_W-1:0] valid_cnt;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            valid_cnt <= '0;
            status_valid <= 1'b0;
        end else if (valid_cnt != `CCS_DET_LIMIT) begin
            valid_cnt <= valid_cnt + `CCS_CNT_W'(1);
            status_valid <= (valid_cnt == `CCS_DET_LIMIT - `CCS_CNT_W'(1));
        end
    end

    // ------------------------------------------------------------
    // sticky change flags, write one to clear
    // ------------------------------------------------------------
    logic [`CCS_NSRC-1:0] rise_flag;
    logic [`CCS_NSRC-1:0] fall_flag;
    logic [`CCS_NSRC-1:0] rise_clr;
    logic [`CCS_NSRC-1:0] fall_clr;

    assign rise_clr = (reg_wr && reg_addr == `CCS_REG_RISE) ?
        reg_wdata[`CCS_NSRC-1:0] : '0;
    assign fall_clr = (reg_wr && reg_addr == `CCS_REG_FALL) ?
        reg_wdata[`CCS_NSRC-1:0] : '0;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rise_flag <= '0;
            fall_flag <= '0;
        end else begin
            // a new event in the clear cycle survives
            rise_flag <= (rise_flag & ~rise_clr) | src_up_evt;
            fall_flag <= (fall_flag & ~fall_clr) | src_down_evt;
        end
    end

    // ------------------------------------------------------------
    // generator control words and switch sequencers
    // ------------------------------------------------------------
    logic [`CCS_SEL_W-1:0] ctrl_sel [0:`CCS_NGEN-1];
    logic [`CCS_NGEN-1:0] ctrl_pd;

    genvar gg;
    generate
        for (gg = 0; gg < `CCS_NGEN; gg = gg + 1) begin : g_gen
            logic [`CCS_SEL_W-1:0] wr_sel;
            logic [`CCS_SEL_W-1:0] stage_sel;
            logic stage_pd;
            logic stage_vld;
            logic [`CCS_SEL_W-1:0] cur_sel;
            logic [`CCS_SEL_W-1:0] tgt_sel;
            logic [`CCS_CNT_W-1:0] sw_cnt;
            logic pll_case;
            logic cur_bit;
            logic gate_on;
            ccs_pkg::ccs_sw_state_t state;

            assign wr_sel = reg_wdata[`CCS_CTRL_SEL_MSB:`CCS_CTRL_SEL_LSB];

            // stage the bus write, then check it against fresh activity
            // the extra stage puts readback two cycles behind the write
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    stage_vld <= 1'b0;
                    stage_sel <= `CCS_SRC_RING;
                    stage_pd <= 1'b0;
                end else begin
                    stage_vld <= reg_wr && reg_addr == `CCS_ADDR_W'(gg);
                    if (reg_wr && reg_addr == `CCS_ADDR_W'(gg)) begin
                        stage_sel <= wr_sel;
                        stage_pd <= reg_wdata[`CCS_CTRL_PD_BIT];
                    end
                end
            end

            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    ctrl_sel[gg] <= `CCS_SRC_RING;
                    ctrl_pd[gg] <= 1'b0;
                end else if (stage_vld) begin
                    ctrl_pd[gg] <= stage_pd;
                    if (ccs_legal(gg, stage_sel, active)) begin
                        ctrl_sel[gg] <= stage_sel;
                    end
                end
            end

            // pll as generator or as new source waits for lock; in hold cur_sel already equals tgt_sel
            assign pll_case = (gg == `CCS_GEN_PLL) ||
                (tgt_sel >= `CCS_SRC_PLL0 && tgt_sel <= `CCS_SRC_PLL240) ||
                (cur_sel >= `CCS_SRC_PLL0 && cur_sel <= `CCS_SRC_PLL240);
            assign cur_bit = src_s[cur_sel];

            // run, drain the old high phase, hold low, resume on a low new phase
            // a drain or resume stuck past the timeout moves on instead of hanging
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    state <= ccs_pkg::CCS_RUN;
                    cur_sel <= `CCS_SRC_RING;
                    tgt_sel <= `CCS_SRC_RING;
                    sw_cnt <= '0;
                end else begin
                    case (state)
                        ccs_pkg::CCS_RUN: begin
                            if (ctrl_sel[gg] != cur_sel) begin
                                tgt_sel <= ctrl_sel[gg];
                                sw_cnt <= '0;
                                state <= ccs_pkg::CCS_DRAIN;
                            end
                        end
                        ccs_pkg::CCS_DRAIN: begin
                            // let the high phase finish; a stuck clock is cut
                            if (!cur_bit || sw_cnt == `CCS_SW_TIMEOUT - `CCS_CNT_W'(1)) begin
                                cur_sel <= tgt_sel;
                                sw_cnt <= '0;
                                state <= ccs_pkg::CCS_HOLD;
                            end else begin
                                sw_cnt <= sw_cnt + `CCS_CNT_W'(1);
                            end
                        end
                        ccs_pkg::CCS_HOLD: begin
                            if (pll_case) begin
                                if (lock_s && sw_cnt >= `CCS_SW_HOLD) begin
                                    sw_cnt <= '0;
                                    state <= ccs_pkg::CCS_RESUME;
                                end
                            end else if (sw_cnt >= `CCS_SW_HOLD) begin
                                sw_cnt <= '0;
                                state <= ccs_pkg::CCS_RESUME;
                            end
                            if (sw_cnt != `CCS_SW_HOLD) begin
                                sw_cnt <= sw_cnt + `CCS_CNT_W'(1);
                            end
                        end
                        ccs_pkg::CCS_RESUME: begin
                            // resume only on a low new source to avoid a runt high;
                            // a new source stuck high is let through rather than hang
                            if (!src_s[cur_sel] ||
                                sw_cnt == `CCS_SW_TIMEOUT - `CCS_CNT_W'(1)) begin
                                state <= ccs_pkg::CCS_RUN;
                            end else begin
                                sw_cnt <= sw_cnt + `CCS_CNT_W'(1);
                            end
                        end
                        default: begin
                            state <= ccs_pkg::CCS_RUN;
                        end
                    endcase
                end
            end

            // safe and control base clocks ignore power-down
            assign gate_on = (state == ccs_pkg::CCS_RUN || state == ccs_pkg::CCS_DRAIN) &&
                (!ctrl_pd[gg] || gg == `CCS_GEN_SAFE || gg == `CCS_GEN_PCR);

            // any number of generators may read the same source
            // registered, so each output trails its source by three cycles
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    gen_clk[gg] <= 1'b0;
                    switch_busy[gg] <= 1'b0;
                end else begin
                    // a dead source still selected is passed as is
                    gen_clk[gg] <= gate_on && cur_bit &&
                        !(state == ccs_pkg::CCS_DRAIN &&
                          sw_cnt == `CCS_SW_TIMEOUT - `CCS_CNT_W'(1));
                    switch_busy[gg] <= (state != ccs_pkg::CCS_RUN) ||
                        (ctrl_sel[gg] != cur_sel);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            // unmapped indices read as zero
            reg_rdata <= '0;
            if (reg_addr < `CCS_ADDR_W'(`CCS_NGEN)) begin
                reg_rdata[`CCS_CTRL_SEL_MSB:`CCS_CTRL_SEL_LSB] <= ctrl_sel[reg_addr];
                reg_rdata[`CCS_CTRL_PD_BIT] <= ctrl_pd[reg_addr];
            end else if (reg_addr == `CCS_REG_STATUS) begin
                reg_rdata[`CCS_NSRC-1:0] <= active;
                reg_rdata[`CCS_STATUS_VALID_BIT] <= status_valid;
            end else if (reg_addr == `CCS_REG_RISE) begin
                reg_rdata[`CCS_NSRC-1:0] <= rise_flag;
            end else if (reg_addr == `CCS_REG_FALL) begin
                reg_rdata[`CCS_NSRC-1:0] <= fall_flag;
            end else if (reg_addr == `CCS_REG_BUSY) begin
                reg_rdata[`CCS_NGEN-1:0] <= switch_busy;
            end
        end
    end

endmodule // ccs_clock_select

// >>> verification/ccs_clock_select_monitor.sv
// concurrent checks on the clock source select block ports
`timescale 1ns/10ps
`include "ccs_consts.svh"

module ccs_clock_select_monitor (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [`CCS_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic ring_osc_source,
    input wire logic xtal_clk,
    input wire logic [`CCS_NPLL_PH-1:0] pll_phase,
    input wire logic [`CCS_NFDIV-1:0] frac_dividers,
    input wire logic pll_lock,
    input wire logic [`CCS_NGEN-1:0] gen_clk,
    input wire logic [`CCS_NSRC-1:0] source_activity_status,
    input wire logic status_valid,
    input wire logic [`CCS_NSRC-1:0] src_up_evt,
    input wire logic [`CCS_NSRC-1:0] src_down_evt,
    input wire logic [`CCS_NGEN-1:0] switch_busy
);
    // ------------------------------------------------------------
    // helper counters, saturating so they never wrap into a false pass
    // ------------------------------------------------------------
    logic [5:0] since_rst;
    logic [5:0] xtal_idle;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            since_rst <= 6'h00;
        end else if (since_rst != 6'h3f) begin
            since_rst <= since_rst + 6'h01;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            xtal_idle <= 6'h00;
        end else if (xtal_clk) begin
            xtal_idle <= 6'h00;
        end else if (xtal_idle != 6'h3f) begin
            xtal_idle <= xtal_idle + 6'h01;
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_sw_start;
        $rose(switch_busy[9]);
    endsequence
    sequence s_sw_end;
        ##[1:200] !switch_busy[9];
    endsequence

    property p_valid_early;
        since_rst < 6'h1e |-> !status_valid;
    endproperty
    property p_valid_late;
        since_rst > 6'h22 |-> status_valid;
    endproperty
    property p_up_evt;
        |(source_activity_status & ~$past(source_activity_status)) |-> ##[0:2] |src_up_evt;
    endproperty
    property p_down_evt;
        |(~source_activity_status & $past(source_activity_status)) |-> ##[0:2] |src_down_evt;
    endproperty
    property p_detect;
        status_valid && $rose(xtal_clk) |-> ##[1:6] source_activity_status[1];
    endproperty
    property p_idle;
        xtal_idle > 6'h28 |-> !source_activity_status[1];
    endproperty
    property p_safe_runs;
        $changed(ring_osc_source) |-> ##[1:8] $changed(gen_clk[`CCS_GEN_SAFE]);
    endproperty
    property p_switch_bound;
        s_sw_start |-> s_sw_end;
    endproperty
    // allow pending plus drain before the clock must sit low
    property p_pll_hold;
        (switch_busy[0] && !pll_lock) [*8] |=> ##4 !gen_clk[0];
    endproperty

    a_valid_early: assert property (p_valid_early) else $error("status valid too early");
    a_valid_late: assert property (p_valid_late) else $error("status valid late");
    a_up_evt: assert property (p_up_evt) else $error("no activation event");
    a_down_evt: assert property (p_down_evt) else $error("no deactivation event");
    a_detect: assert property (p_detect) else $error("active source not seen");
    a_idle: assert property (p_idle) else $error("idle source still active");
    a_safe_runs: assert property (p_safe_runs) else $error("safe clock stalled");
    a_switch_bound: assert property (p_switch_bound) else $error("switch hung");
    a_pll_hold: assert property (p_pll_hold) else $error("pll clock not held low");
endmodule // ccs_clock_select_monitor

bind ccs_clock_select ccs_clock_select_monitor u_mon (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ring_osc_source(ring_osc_source), .xtal_clk(xtal_clk),
    .pll_phase(pll_phase), .frac_dividers(frac_dividers), .pll_lock(pll_lock),
    .gen_clk(gen_clk), .source_activity_status(source_activity_status),
    .status_valid(status_valid), .src_up_evt(src_up_evt), .src_down_evt(src_down_evt),
    .switch_busy(switch_busy));

// >>> verification/test_clock_source_select_detect.sv
// self-checking bench for the clock source select block
`timescale 1ns/10ps
`include "ccs_consts.svh"

module test_clock_source_select_detect;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [`CCS_ADDR_W-1:0] reg_addr = 5'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic pll_lock = 1'b1;
    logic [`CCS_NSRC-1:0] src_en = 12'h03f;
    logic [`CCS_NSRC-1:0] src = 12'h000;
    logic [3:0] tick = 4'h0;
    logic [31:0] reg_rdata;
    logic [`CCS_NGEN-1:0] gen_clk;
    logic [`CCS_NGEN-1:0] switch_busy;
    logic [`CCS_NSRC-1:0] act;
    logic [`CCS_NSRC-1:0] up_evt;
    logic [`CCS_NSRC-1:0] down_evt;
    logic status_valid;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;

    ccs_clock_select u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ring_osc_source(src[0]), .xtal_clk(src[1]), .pll_phase(src[4:2]),
        .frac_dividers(src[11:5]), .pll_lock(pll_lock), .gen_clk(gen_clk),
        .source_activity_status(act), .status_valid(status_valid), .src_up_evt(up_evt),
        .src_down_evt(down_evt), .switch_busy(switch_busy));

    // ------------------------------------------------------------
    // clock, slow sources and hang guard
    // ------------------------------------------------------------
    always #2.5 clk_sys = ~clk_sys;
    // sources toggle every 4 cycles, well below the sampling rate
    always_ff @(posedge clk_sys) begin
        tick <= tick + 4'h1;
        src <= src_en & {12{tick[2]}};
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e,
            input string what);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(what, e, reg_rdata & m);
    endtask
    // the select lands two cycles after the write
    task automatic wrchk(input logic [4:0] a, input logic [31:0] d, input logic [31:0] e);
        wr(a, d);
        repeat (3) @(posedge clk_sys);
        rd(a, 32'h0000_010f, e, "control word");
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        #1;
        while (n < 300 && switch_busy !== 17'h00000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk("switch_busy", 32'h0000_0000, {15'h0000, switch_busy});
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(`CCS_REG_STATUS, 32'h0001_0fff, 32'h0000_0000, "status at reset");
        for (int g = 0; g < `CCS_NGEN; g++) rd(5'(g), 32'h0000_000f, 32'h0, "reset select");
        repeat (40) @(posedge clk_sys);
        #1;
        chk("activity port", 32'h0000_003f, {20'h00000, act});
        chk("valid port", 32'h0000_0001, {31'h0, status_valid});
        rd(`CCS_REG_STATUS, 32'h0001_0fff, 32'h0001_003f, "status settled");
        $display("test reset done");
    endtask
    task automatic t_select();
        logic [`CCS_NGEN-1:0] seen;
        rd(`CCS_REG_STATUS, 32'h0000_0002, 32'h0000_0002, "crystal running");
        wrchk(5'h09, 32'h0000_0101, 32'h0000_0101);
        wrchk(5'h0b, 32'h0000_0001, 32'h0000_0001);
        wrchk(5'h01, 32'h0000_0002, 32'h0000_0002);
        wrchk(5'h02, 32'h0000_0004, 32'h0000_0004);
        wrchk(5'h10, 32'h0000_0005, 32'h0000_0005);
        wait_idle();
        // gen 9 is powered down, the rest listed must toggle
        seen = 17'h00000;
        repeat (16) begin
            @(posedge clk_sys);
            #1;
            seen = seen | gen_clk;
        end
        chk("generated clocks", 32'h0001_0d07, {15'h0000, seen & 17'h10f07});
        $display("test select done");
    endtask
    task automatic t_refuse();
        wrchk(5'h00, 32'h0000_0105, 32'h0000_0100);
        wrchk(5'h00, 32'h0000_0003, 32'h0000_0000);
        wrchk(5'h03, 32'h0000_0005, 32'h0000_0000);
        wrchk(5'h08, 32'h0000_0001, 32'h0000_0000);
        wrchk(5'h0a, 32'h0000_0002, 32'h0000_0000);
        wrchk(5'h09, 32'h0000_0006, 32'h0000_0001);
        src_en[6] <= 1'b1;
        repeat (10) @(posedge clk_sys);
        wrchk(5'h09, 32'h0000_0006, 32'h0000_0006);
        wait_idle();
        rd(5'h1f, 32'hffff_ffff, 32'h0000_0000, "unmapped read");
        $display("test refuse done");
    endtask
    task automatic t_pll();
        @(posedge clk_sys);
        pll_lock <= 1'b0;
        wr(5'h00, 32'h0000_0001);
        repeat (60) @(posedge clk_sys);
        #1;
        chk("pll switch busy", 32'h1, {31'h0, switch_busy[0]});
        chk("pll clock low", 32'h0, {31'h0, gen_clk[0]});
        @(posedge clk_sys);
        pll_lock <= 1'b1;
        wait_idle();
        rd(5'h00, 32'h0000_010f, 32'h0000_0001, "pll select");
        $display("test pll done");
    endtask
    task automatic t_loss();
        src_en[1] <= 1'b0;
        repeat (45) @(posedge clk_sys);
        rd(`CCS_REG_STATUS, 32'h0000_0002, 32'h0, "crystal gone");
        rd(`CCS_REG_FALL, 32'h0000_0002, 32'h0000_0002, "fall flag");
        wr(`CCS_REG_FALL, 32'h0000_0002);
        wr(`CCS_REG_RISE, 32'h0000_0002);
        rd(`CCS_REG_FALL, 32'h0000_0002, 32'h0, "fall cleared");
        src_en[1] <= 1'b1;
        repeat (12) @(posedge clk_sys);
        rd(`CCS_REG_RISE, 32'h0000_0002, 32'h0000_0002, "rise flag");
        $display("test loss done");
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_select();
        t_refuse();
        t_pll();
        t_loss();
        stop_test();
    end
endmodule // test_clock_source_select_detect
